//--- inc/t3c_pkg.sv
// constants and carrier types of the timer 3 control block
`default_nettype none

package t3c_pkg;

	// ***********************************************************
	// register map
	// ***********************************************************
	localparam logic [7:0] ADDR_CTRL      = 8'h91;
	localparam logic [7:0] ADDR_RELOAD_LO = 8'h92;
	localparam logic [7:0] ADDR_RELOAD_HI = 8'h93;
	localparam logic [7:0] ADDR_COUNT_LO  = 8'h94;
	localparam logic [7:0] ADDR_COUNT_HI  = 8'h95;
	localparam logic [7:0] CTRL_RESET     = 8'h00;
	localparam logic [7:0] BYTE_RESET     = 8'h00;
	localparam logic [7:0] BYTE_MAX       = 8'hff;
	localparam logic [7:0] BYTE_ZERO      = 8'h00;
	localparam logic [7:0] READ_UNMAPPED  = 8'h00;

	// ***********************************************************
	// source dividers
	// ***********************************************************
	localparam int         SYS_DIV      = 12;
	localparam int         SRC_DIV      = 8;
	localparam logic [3:0] SYS_DIV_LAST = 4'(SYS_DIV - 1);
	localparam logic [2:0] SRC_DIV_LAST = 3'(SRC_DIV - 1);

	// alternate clock select codes
	localparam logic [1:0] ALT_SYS12 = 2'h0;
	localparam logic [1:0] ALT_EXT8  = 2'h1;
	localparam logic [1:0] ALT_RSVD  = 2'h2;
	localparam logic [1:0] ALT_LFO8  = 2'h3;

	// control register, bit 7 down to bit 0
	typedef struct packed {
		logic       high_byte_overflow_flag;
		logic       low_byte_overflow_flag;
		logic       low_byte_irq_enable;
		logic       osc_capture_enable;
		logic       split_mode_enable;
		logic       run_control;
		logic [1:0] alt_clock_select;
	} t3c_ctrl_t;

	// count strobes from the clock source selector
	typedef struct packed {
		logic tick_hi;
		logic tick_lo;
		logic lfo_fall;
	} t3c_tick_t;

endpackage

`default_nettype wire

//--- verilog/t3c_clk_src.sv
// clock source selection, pin synchronisers and dividers for timer 3
`default_nettype none

module t3c_clk_src (
	// clock and reset
	input  wire logic            clk_i,
	input  wire logic            rst_i,
	input  wire logic            ce_i,
	// asynchronous pins
	input  wire logic            ext_clk_i,
	input  wire logic            low_freq_oscillator_i,
	// selection
	input  wire logic [1:0]      alt_clock_select_i,
	input  wire logic            high_byte_fast_clock_select_i,
	input  wire logic            low_byte_fast_clock_select_i,
	// strobes
	output t3c_pkg::t3c_tick_t   tick_o
);
	import t3c_pkg::*;

	// ***********************************************************
	// pin synchronisers, index 0 external clock, 1 oscillator
	// ***********************************************************
	logic [1:0] pin_raw;
	logic [1:0] sync1;
	logic [1:0] sync2;
	logic [1:0] sync3;
	logic [1:0] stable;
	logic [1:0] rise;
	logic [1:0] fall;
	logic [1:0] div_tick;
	logic [3:0] sys_cnt;
	logic       sys_tick;
	logic       alt_tick;

	assign pin_raw = {low_freq_oscillator_i, ext_clk_i};

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_pin
			logic [2:0] div_cnt;
			// three stages; a change counts only once stages two and three agree
			always_ff @(posedge clk_i or posedge rst_i) begin
				// each lane clears only its own bit so the lanes never share a driver
				if (rst_i) begin
					sync1[g]  <= 1'b0;
					sync2[g]  <= 1'b0;
					sync3[g]  <= 1'b0;
					stable[g] <= 1'b0;
				end else if (ce_i) begin
					sync1[g] <= pin_raw[g];
					sync2[g] <= sync1[g];
					sync3[g] <= sync2[g];
					if (sync2[g] == sync3[g]) begin
						stable[g] <= sync3[g];
					end
				end
			end
			assign rise[g] = (sync2[g] == sync3[g]) && sync3[g] && !stable[g];
			assign fall[g] = (sync2[g] == sync3[g]) && !sync3[g] && stable[g];
			// divide by eight on synchronised rising edges
			always_ff @(posedge clk_i or posedge rst_i) begin
				if (rst_i) begin
					div_cnt <= 3'h0;
				end else if (ce_i && rise[g]) begin
					div_cnt <= div_cnt + 3'h1;
				end
			end
			assign div_tick[g] = rise[g] && (div_cnt == SRC_DIV_LAST);
		end
	endgenerate

	// system clock prescaler by twelve
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			sys_cnt <= 4'h0;
		end else if (ce_i) begin
			sys_cnt <= (sys_cnt == SYS_DIV_LAST) ? 4'h0 : sys_cnt + 4'h1;
		end
	end
	assign sys_tick = (sys_cnt == SYS_DIV_LAST);

	// alternate source; reserved code gives no strobe at all
	always_comb begin
		unique case (alt_clock_select_i)
			ALT_SYS12: alt_tick = sys_tick;
			ALT_EXT8:  alt_tick = div_tick[0];
			ALT_RSVD:  alt_tick = 1'b0;
			ALT_LFO8:  alt_tick = div_tick[1];
		endcase
	end

	// registered strobes; both bytes share the alternate source
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			tick_o <= '0;
		end else if (ce_i) begin
			tick_o.tick_hi  <= high_byte_fast_clock_select_i | alt_tick;
			tick_o.tick_lo  <= low_byte_fast_clock_select_i | alt_tick;
			tick_o.lfo_fall <= fall[1];
		end
	end

	// ***********************************************************
	// checks
	// ***********************************************************
	a_reserved_idle: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && alt_clock_select_i == ALT_RSVD && !low_byte_fast_clock_select_i
		|=> !tick_o.tick_lo)
		else $error("reserved clock select produced a low byte strobe");

endmodule

`default_nettype wire

//--- verilog/t3c_top.sv
// timer 3 counter, reload, flags and control register with its special register port
`default_nettype none

module t3c_top (
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       ce_i,
	// special function register port
	input  wire logic [7:0] sfr_addr_i,
	input  wire logic       sfr_wr_i,
	input  wire logic       sfr_rd_i,
	input  wire logic [7:0] sfr_wdata_i,
	output logic [7:0]      sfr_rdata_o,
	// clock control bits and interrupt enable from elsewhere
	input  wire logic       high_byte_fast_clock_select_i,
	input  wire logic       low_byte_fast_clock_select_i,
	input  wire logic       timer_irq_enable_i,
	// pins
	input  wire logic       ext_clk_i,
	input  wire logic       low_freq_oscillator_i,
	// interrupt request
	output logic            timer_irq_o
);
	import t3c_pkg::*;

	t3c_ctrl_t  ctrl;
	t3c_tick_t  tick;
	logic [7:0] count_lo;
	logic [7:0] count_hi;
	logic [7:0] reload_lo;
	logic [7:0] reload_hi;
	logic [7:0] next_count_lo;
	logic [7:0] next_count_hi;
	logic       wr_ctrl;
	logic       wr_rl_lo;
	logic       wr_rl_hi;
	logic       wr_cnt_lo;
	logic       wr_cnt_hi;
	logic       inc_lo;
	logic       inc_hi;
	logic       lo_ovf;
	logic       hi_ovf;
	logic       wrap16;
	logic       cap_evt;
	logic       set_hi;
	logic       set_lo;

	// ***********************************************************
	// clock sources
	// ***********************************************************
	t3c_clk_src u_clk_src (
		.clk_i                         (clk_i),
		.rst_i                         (rst_i),
		.ce_i                          (ce_i),
		.ext_clk_i                     (ext_clk_i),
		.low_freq_oscillator_i         (low_freq_oscillator_i),
		.alt_clock_select_i            (ctrl.alt_clock_select),
		.high_byte_fast_clock_select_i (high_byte_fast_clock_select_i),
		.low_byte_fast_clock_select_i  (low_byte_fast_clock_select_i),
		.tick_o                        (tick)
	);

	// ***********************************************************
	// register decode
	// ***********************************************************
	assign wr_ctrl   = ce_i && sfr_wr_i && (sfr_addr_i == ADDR_CTRL);
	assign wr_rl_lo  = ce_i && sfr_wr_i && (sfr_addr_i == ADDR_RELOAD_LO);
	assign wr_rl_hi  = ce_i && sfr_wr_i && (sfr_addr_i == ADDR_RELOAD_HI);
	assign wr_cnt_lo = ce_i && sfr_wr_i && (sfr_addr_i == ADDR_COUNT_LO);
	assign wr_cnt_hi = ce_i && sfr_wr_i && (sfr_addr_i == ADDR_COUNT_HI);

	// ***********************************************************
	// count events
	// ***********************************************************
	// low byte runs free in split mode, follows run control otherwise
	assign inc_lo = ce_i && tick.tick_lo &&
		(ctrl.split_mode_enable || ctrl.run_control);
	assign inc_hi = ctrl.split_mode_enable ?
		(ce_i && tick.tick_hi && ctrl.run_control) :
		(inc_lo && count_lo == BYTE_MAX);
	assign lo_ovf  = inc_lo && (count_lo == BYTE_MAX);
	assign wrap16  = !ctrl.split_mode_enable && lo_ovf && (count_hi == BYTE_MAX);
	assign hi_ovf  = inc_hi && (count_hi == BYTE_MAX);
	assign cap_evt = ce_i && ctrl.osc_capture_enable && tick.lfo_fall;
	assign set_hi  = hi_ovf || cap_evt;
	assign set_lo  = lo_ovf;

	// next count values; reload on wrap, own byte in split mode
	always_comb begin
		next_count_lo = count_lo;
		next_count_hi = count_hi;
		if (inc_lo) begin
			if (lo_ovf && (ctrl.split_mode_enable || wrap16)) begin
				next_count_lo = reload_lo;
			end else begin
				next_count_lo = count_lo + 8'h01;
			end
		end
		if (inc_hi) begin
			if (hi_ovf) begin
				next_count_hi = reload_hi;
			end else begin
				next_count_hi = count_hi + 8'h01;
			end
		end
	end

	// ***********************************************************
	// count registers; a software write overrides a count step
	// ***********************************************************
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			count_lo <= BYTE_RESET;
			count_hi <= BYTE_RESET;
		end else if (ce_i) begin
			count_lo <= wr_cnt_lo ? sfr_wdata_i : next_count_lo;
			count_hi <= wr_cnt_hi ? sfr_wdata_i : next_count_hi;
		end
	end

	// reload pair; capture wins over software so no measurement is lost
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			reload_lo <= BYTE_RESET;
			reload_hi <= BYTE_RESET;
		end else if (cap_evt) begin
			reload_lo <= count_lo;
			reload_hi <= count_hi;
		end else begin
			if (wr_rl_lo) begin
				reload_lo <= sfr_wdata_i;
			end
			if (wr_rl_hi) begin
				reload_hi <= sfr_wdata_i;
			end
		end
	end

	// ***********************************************************
	// control register and flags
	// ***********************************************************
	// flags are only cleared by a write; a same-cycle set always survives
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ctrl <= CTRL_RESET;
		end else if (ce_i) begin
			if (wr_ctrl) begin
				ctrl <= sfr_wdata_i;
			end
			if (set_hi) begin
				ctrl.high_byte_overflow_flag <= 1'b1;
			end
			if (set_lo) begin
				ctrl.low_byte_overflow_flag <= 1'b1;
			end
		end
	end

	// interrupt request level, cleared through the flags or by dropping timer_irq_enable_i
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			timer_irq_o <= 1'b0;
		end else if (ce_i) begin
			timer_irq_o <= timer_irq_enable_i && (ctrl.high_byte_overflow_flag ||
				(ctrl.low_byte_irq_enable && ctrl.low_byte_overflow_flag));
		end
	end

	// read data, one cycle after the read strobe
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			sfr_rdata_o <= READ_UNMAPPED;
		end else if (ce_i && sfr_rd_i) begin
			unique case (sfr_addr_i)
				ADDR_CTRL:      sfr_rdata_o <= ctrl;
				ADDR_RELOAD_LO: sfr_rdata_o <= reload_lo;
				ADDR_RELOAD_HI: sfr_rdata_o <= reload_hi;
				ADDR_COUNT_LO:  sfr_rdata_o <= count_lo;
				ADDR_COUNT_HI:  sfr_rdata_o <= count_hi;
				default:        sfr_rdata_o <= READ_UNMAPPED;
			endcase
		end
	end

	// ***********************************************************
	// checks
	// ***********************************************************
	a_hi_flag_set: assert property (@(posedge clk_i) disable iff (rst_i)
		hi_ovf |=> ctrl.high_byte_overflow_flag)
		else $error("high byte overflow did not set the high flag");

	a_wrap_reload: assert property (@(posedge clk_i) disable iff (rst_i)
		wrap16 && !wr_cnt_lo && !wr_cnt_hi && !cap_evt
		|=> {count_hi, count_lo} == $past({reload_hi, reload_lo}))
		else $error("16-bit wrap did not load the reload pair");

	a_lo_flag_set: assert property (@(posedge clk_i) disable iff (rst_i)
		lo_ovf |=> ctrl.low_byte_overflow_flag)
		else $error("low byte overflow did not set the low flag");

	a_hi_flag_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
		ctrl.high_byte_overflow_flag && !wr_ctrl |=> ctrl.high_byte_overflow_flag)
		else $error("high flag cleared without a software write");

	a_lo_flag_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
		ctrl.low_byte_overflow_flag && !wr_ctrl |=> ctrl.low_byte_overflow_flag)
		else $error("low flag cleared without a software write");

	a_set_wins_clear: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_ctrl && set_hi |=> ctrl.high_byte_overflow_flag)
		else $error("software clear beat a hardware set");

	a_irq_from_high: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && timer_irq_enable_i && ctrl.high_byte_overflow_flag |=> timer_irq_o)
		else $error("high flag did not raise the interrupt");

	a_irq_from_low: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && timer_irq_enable_i && ctrl.low_byte_irq_enable
		&& ctrl.low_byte_overflow_flag |=> timer_irq_o)
		else $error("enabled low flag did not raise the interrupt");

	a_capture_copy: assert property (@(posedge clk_i) disable iff (rst_i)
		cap_evt |=> {reload_hi, reload_lo} == $past({count_hi, count_lo})
		&& ctrl.high_byte_overflow_flag)
		else $error("capture did not copy the count and set the high flag");

	a_capture_irq: assert property (@(posedge clk_i) disable iff (rst_i)
		cap_evt && timer_irq_enable_i ##1 ce_i && timer_irq_enable_i |=> timer_irq_o)
		else $error("capture event raised no interrupt");

	a_hold_stopped: assert property (@(posedge clk_i) disable iff (rst_i)
		!ctrl.split_mode_enable && !ctrl.run_control && !wr_cnt_lo && !wr_cnt_hi
		|=> $stable({count_hi, count_lo}))
		else $error("stopped 16-bit counter moved");

	a_split_lo_free: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && ctrl.split_mode_enable && !ctrl.run_control && tick.tick_lo && !wr_cnt_lo
		|=> count_lo != $past(count_lo) && $stable(count_hi) || $past(wr_cnt_hi))
		else $error("split mode low byte did not count with run control off");

endmodule

`default_nettype wire

//--- verification/t3c_cpu_model.sv
// cpu side model driving the timer 3 special function register port
`default_nettype none

module t3c_cpu_model (
	// clock
	input  wire logic       clk_i,
	// special function register port
	output var logic [7:0]  sfr_addr_o,
	output var logic        sfr_wr_o,
	output var logic        sfr_rd_o,
	output var logic [7:0]  sfr_wdata_o,
	input  wire logic [7:0] sfr_rdata_i
);
	timeunit 1ns;
	timeprecision 1ps;

	// ***********************************************************
	// bus cycles
	// ***********************************************************
	// idle bus at time zero, strobes low
	initial begin
		sfr_addr_o  = 8'h00;
		sfr_wr_o    = 1'b0;
		sfr_rd_o    = 1'b0;
		sfr_wdata_o = 8'h00;
	end

	// one write; released lines show the inverse so stale data never looks valid
	task automatic sfr_write(input logic [7:0] addr, input logic [7:0] data);
		@(posedge clk_i);
		sfr_addr_o  <= addr;
		sfr_wdata_o <= data;
		sfr_wr_o    <= 1'b1;
		@(posedge clk_i);
		sfr_wr_o    <= 1'b0;
		sfr_addr_o  <= ~addr;
		sfr_wdata_o <= ~data;
	endtask

	// one read; registered data lands at the taken edge
	task automatic sfr_read(input logic [7:0] addr, output logic [7:0] data);
		@(posedge clk_i);
		sfr_addr_o <= addr;
		sfr_rd_o   <= 1'b1;
		@(posedge clk_i);
		sfr_rd_o   <= 1'b0;
		sfr_addr_o <= ~addr;
		#1;
		data = sfr_rdata_i;
	endtask

endmodule

`default_nettype wire

//--- verification/t3c_top_tb_top.sv
// self-checking bench for the timer 3 control and flag logic
`default_nettype none

module t3c_top_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import t3c_pkg::*;

	// ***********************************************************
	// signals
	// ***********************************************************
	logic       clk_i;
	logic       rst_i;
	logic       hi_fast;
	logic       lo_fast;
	logic       irq_en;
	logic       pin_run;
	logic       lfo_lvl;
	logic       pin_tog;
	logic [1:0] ph;
	logic [7:0] sfr_addr;
	logic       sfr_wr;
	logic       sfr_rd;
	logic [7:0] sfr_wdata;
	logic [7:0] sfr_rdata;
	logic       irq;
	int         n_fail;
	int         n_tests;

	// 125 MHz system clock
	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end

	// pins toggle every 3 cycles only inside a counting window; otherwise the external pin is low and the oscillator pin follows lfo_lvl
	always @(posedge clk_i) begin
		if (rst_i) begin
			ph      <= 2'h0;
			pin_tog <= 1'b0;
		end else begin
			ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
			if (ph == 2'h2) begin
				pin_tog <= ~pin_tog;
			end
		end
	end

	t3c_cpu_model cpu (
		.clk_i       (clk_i),
		.sfr_addr_o  (sfr_addr),
		.sfr_wr_o    (sfr_wr),
		.sfr_rd_o    (sfr_rd),
		.sfr_wdata_o (sfr_wdata),
		.sfr_rdata_i (sfr_rdata)
	);

	t3c_top dut (
		.clk_i                         (clk_i),
		.rst_i                         (rst_i),
		.ce_i                          (1'b1),
		.sfr_addr_i                    (sfr_addr),
		.sfr_wr_i                      (sfr_wr),
		.sfr_rd_i                      (sfr_rd),
		.sfr_wdata_i                   (sfr_wdata),
		.sfr_rdata_o                   (sfr_rdata),
		.high_byte_fast_clock_select_i (hi_fast),
		.low_byte_fast_clock_select_i  (lo_fast),
		.timer_irq_enable_i            (irq_en),
		.ext_clk_i                     (pin_run & pin_tog),
		.low_freq_oscillator_i         (pin_run ? pin_tog : lfo_lvl),
		.timer_irq_o                   (irq)
	);

	// ***********************************************************
	// helpers
	// ***********************************************************
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask

	task automatic give_verdict();
		if (n_fail == 0 && n_tests > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		cpu.sfr_read(a, d);
		check({8'h00, d}, {8'h00, exp});
	endtask

	// range test for counts whose exact phase is not fixed
	task automatic rng(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
		check({15'h0000, (v >= lo) && (v <= hi)}, 16'h0001);
	endtask

	// poll the control register until a flag bit shows, bounded
	task automatic wait_flag(input int b);
		logic [7:0] d;
		int         k;
		d = 8'h00;
		for (k = 0; k < 400 && d[b] !== 1'b1; k++) begin
			cpu.sfr_read(ADDR_CTRL, d);
		end
		if (d[b] !== 1'b1) begin
			n_fail++;
			give_verdict();
		end
	endtask

	// ***********************************************************
	// scenarios
	// ***********************************************************
	initial begin
		logic [7:0]  d;
		logic [15:0] cap;
		logic [15:0] cnt;
		int          i;
		int          lo_t[4];
		int          hi_t[4];
		lo_t = '{19, 4, 0, 4};
		hi_t = '{22, 7, 0, 7};
		rst_i = 1'b1;
		hi_fast = 1'b1;
		lo_fast = 1'b1;
		irq_en = 1'b1;
		pin_run = 1'b0;
		lfo_lvl = 1'b0;
		n_fail = 0;
		n_tests = 0;
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		// reset values, unmapped place, control read back
		for (i = 0; i < 5; i++) rd_chk(ADDR_CTRL + 8'(i), CTRL_RESET);
		rd_chk(8'h90, READ_UNMAPPED);
		cpu.sfr_write(8'h96, 8'h5a);
		rd_chk(8'h96, READ_UNMAPPED);
		cpu.sfr_write(ADDR_CTRL, 8'h5a);
		rd_chk(ADDR_CTRL, 8'h5a);
		cpu.sfr_write(ADDR_CTRL, 8'h00);
		// 16-bit wrap with reload, flags sticky until software clears
		cpu.sfr_write(ADDR_RELOAD_LO, 8'h34);
		cpu.sfr_write(ADDR_RELOAD_HI, 8'h12);
		cpu.sfr_write(ADDR_COUNT_LO, 8'hfd);
		cpu.sfr_write(ADDR_COUNT_HI, 8'hff);
		repeat (20) @(posedge clk_i);
		rd_chk(ADDR_COUNT_LO, 8'hfd);
		cpu.sfr_write(ADDR_CTRL, 8'h04);
		wait_flag(7);
		rd_chk(ADDR_CTRL, 8'hc4);
		cpu.sfr_write(ADDR_CTRL, 8'hc0);
		rd_chk(ADDR_CTRL, 8'hc0);
		rd_chk(ADDR_COUNT_HI, 8'h12);
		check({15'h0000, irq}, 16'h0001);
		repeat (50) @(posedge clk_i);
		rd_chk(ADDR_CTRL, 8'hc0);
		cpu.sfr_write(ADDR_CTRL, 8'h00);
		repeat (3) @(posedge clk_i);
		check({15'h0000, irq}, 16'h0001 ^ 16'h0001);
		// split mode: low byte runs with run control off
		cpu.sfr_write(ADDR_RELOAD_LO, 8'hf0);
		cpu.sfr_write(ADDR_COUNT_LO, 8'hf0);
		cpu.sfr_write(ADDR_COUNT_HI, 8'h55);
		cpu.sfr_write(ADDR_RELOAD_HI, 8'ha0);
		cpu.sfr_write(ADDR_CTRL, 8'h08);
		wait_flag(6);
		rd_chk(ADDR_COUNT_HI, 8'h55);
		check({15'h0000, irq}, 16'h0000);
		cpu.sfr_write(ADDR_CTRL, 8'h68);
		repeat (3) @(posedge clk_i);
		check({15'h0000, irq}, 16'h0001);
		irq_en <= 1'b0;
		repeat (3) @(posedge clk_i);
		check({15'h0000, irq}, 16'h0000);
		irq_en <= 1'b1;
		cpu.sfr_read(ADDR_COUNT_LO, d);
		rng({8'h00, d}, 16'h00f0, 16'h00ff);
		cpu.sfr_write(ADDR_COUNT_HI, 8'hfe);
		cpu.sfr_write(ADDR_CTRL, 8'h0c);
		wait_flag(7);
		cpu.sfr_read(ADDR_COUNT_HI, d);
		rng({8'h00, d}, 16'h00a0, 16'h00bf);
		// high byte overflows in the very cycle of a flag-clearing write
		cpu.sfr_write(ADDR_CTRL, 8'h0c);
		cpu.sfr_write(ADDR_COUNT_HI, 8'hfe);
		cpu.sfr_write(ADDR_CTRL, 8'h0c);
		cpu.sfr_read(ADDR_CTRL, d);
		check({15'h0000, d[7]}, 16'h0001);
		// reserved source on the high byte holds it still
		cpu.sfr_write(ADDR_CTRL, 8'h0e);
		hi_fast <= 1'b0;
		cpu.sfr_read(ADDR_COUNT_HI, d);
		repeat (20) @(posedge clk_i);
		rd_chk(ADDR_COUNT_HI, d);
		hi_fast <= 1'b1;
		// each alternate source over a 240 cycle window, 16-bit mode
		lo_fast <= 1'b0;
		for (i = 0; i < 4; i++) begin
			cpu.sfr_write(ADDR_CTRL, 8'(i));
			cpu.sfr_write(ADDR_COUNT_LO, 8'h00);
			cpu.sfr_write(ADDR_COUNT_HI, 8'h00);
			pin_run <= 1'b1;
			cpu.sfr_write(ADDR_CTRL, 8'h04 | 8'(i));
			repeat (240) @(posedge clk_i);
			cpu.sfr_write(ADDR_CTRL, 8'(i));
			pin_run <= 1'b0;
			cpu.sfr_read(ADDR_COUNT_LO, d);
			rng({8'h00, d}, 16'(lo_t[i]), 16'(hi_t[i]));
		end
		// oscillator capture on a falling edge
		lo_fast <= 1'b1;
		lfo_lvl <= 1'b1;
		cpu.sfr_write(ADDR_CTRL, 8'h00);
		cpu.sfr_write(ADDR_COUNT_LO, 8'h00);
		cpu.sfr_write(ADDR_COUNT_HI, 8'h00);
		cpu.sfr_write(ADDR_CTRL, 8'h14);
		repeat (20) @(posedge clk_i);
		lfo_lvl <= 1'b0;
		repeat (10) @(posedge clk_i);
		rd_chk(ADDR_CTRL, 8'h94);
		cpu.sfr_write(ADDR_CTRL, 8'h90);
		rd_chk(ADDR_CTRL, 8'h90);
		check({15'h0000, irq}, 16'h0001);
		cpu.sfr_read(ADDR_RELOAD_LO, cap[7:0]);
		cpu.sfr_read(ADDR_RELOAD_HI, cap[15:8]);
		cpu.sfr_read(ADDR_COUNT_LO, cnt[7:0]);
		cpu.sfr_read(ADDR_COUNT_HI, cnt[15:8]);
		rng(cap, 16'h0010, cnt - 16'h0001);
		give_verdict();
	end

endmodule

`default_nettype wire
